// >>> logic/sbc_pkg.sv
// Package for the serial bit-rate and card format block: map, fields, counts, types
package sbc_pkg;

   // ==========================================================
   // Register offsets (byte addresses, one 32-bit word each)
   localparam logic [7:0] SBC_OFS_CARD_MODE   = 8'h00;
   localparam logic [7:0] SBC_OFS_DIVISOR     = 8'h04;
   localparam logic [7:0] SBC_OFS_SERIAL_MODE = 8'h08;
   localparam logic [7:0] SBC_OFS_STATUS      = 8'h0C;

   // ==========================================================
   // Card mode control field positions and reset value
   localparam int         SBC_CM_MODE_BIT  = 0;
   localparam int         SBC_CM_INV_BIT   = 2;
   localparam int         SBC_CM_ORDER_BIT = 3;
   localparam logic [7:0] SBC_CM_FIXED_ONES = 8'hF2;
   localparam logic [7:0] SBC_DIVISOR_RESET = 8'hFF;

   // ==========================================================
   // Serial mode field positions
   localparam int SBC_SM_PRE_LO   = 0;
   localparam int SBC_SM_BASE_LO  = 2;
   localparam int SBC_SM_SEVEN    = 4;
   localparam int SBC_SM_ODD      = 5;
   localparam int SBC_SM_SYNC     = 6;
   localparam logic [6:0] SBC_SM_RESET = 7'h00;

   // ==========================================================
   // Base clocks per bit after the divider, per mode
   localparam logic [9:0] SBC_ASYNC_BASE = 10'h020;  // 64 x 2^(2n-1) = 32 x 4^n
   localparam logic [9:0] SBC_SYNC_BASE  = 10'h004;  // 8 x 2^(2n-1) = 4 x 4^n
   localparam logic [9:0] SBC_CARD_S0    = 10'h020;  // S = 32
   localparam logic [9:0] SBC_CARD_S1    = 10'h040;  // S = 64
   localparam logic [9:0] SBC_CARD_S2    = 10'h174;  // S = 372
   localparam logic [9:0] SBC_CARD_S3    = 10'h100;  // S = 256

   // ==========================================================
   // Types
   typedef struct packed {
      logic       sync_mode;
      logic       parity_odd;
      logic       char_seven;
      logic [1:0] base_clock_count;
      logic [1:0] prescale_select;
   } sbc_smode_type;

   typedef struct packed {
      logic [7:0]    divisor;
      logic          card_bit_order;
      logic          card_data_invert;
      logic          card_mode_select;
      sbc_smode_type smode;
      logic [5:0]    pre_cnt;
      logic [7:0]    div_cnt;
      logic [9:0]    bit_cnt;
      logic          base_tick;
      logic          bit_tick;
      logic          ack;
      logic [31:0]   rdata;
      logic          head_valid;
      logic [7:0]    head_data;
      logic          tail_valid;
      logic [7:0]    tail_data;
      logic          tx_ready;
      logic          rx_valid;
      logic [7:0]    rx_data;
      logic          rx_ready;
   } sbc_state_type;

   // Data bits only: inversion then bit reversal, 8-bit frames only reverse
   function automatic logic [7:0] sbc_format(input logic [7:0] d,
                                             input logic       inv,
                                             input logic       msb_first,
                                             input logic       seven);
      logic [7:0] r;
      r = d;
      if (inv) begin
         r = seven ? {d[7], ~d[6:0]} : ~d;
      end
      if (msb_first && !seven) begin
         r = {r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
      end
      return r;
   endfunction : sbc_format

endpackage : sbc_pkg

// >>> logic/sbc_top.sv
// Bit-rate generator and card format control for one serial channel, Wishbone slave
`timescale 1ns/1ps
module sbc_top
   import sbc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // Raw transmit characters from the transmit buffer
   input  wire logic        tx_valid_i,
   input  wire logic [7:0]  tx_data_i,
   output logic             tx_ready_o,
   // Formatted characters to the transmit shifter
   output logic             tx_valid_o,
   output logic [7:0]       tx_data_o,
   input  wire logic        tx_ready_i,
   // Raw characters from the receive shifter
   input  wire logic        rx_valid_i,
   input  wire logic [7:0]  rx_data_i,
   output logic             rx_ready_o,
   // Formatted characters to the receive buffer
   output logic             rx_valid_o,
   output logic [7:0]       rx_data_o,
   input  wire logic        rx_ready_i,
   // Timing and mode to the shift engines
   output logic             base_tick_o,
   output logic             bit_tick_o,
   output logic             card_mode_o,
   output logic             sync_mode_o,
   output logic             char_seven_o,
   output logic             parity_odd_o
);

   // ==========================================================
   // State
   sbc_state_type s;
   sbc_state_type next_s;

   // ==========================================================
   // Decoded helpers
   logic       bus_req;
   logic       wr_en;
   logic [5:0] pre_limit;
   logic [9:0] bits_base;
   logic [9:0] card_s;
   logic       pre_tick;
   logic       tx_take;
   logic       tx_pop;
   logic       rx_take;
   logic       rx_pop;
   logic [7:0] tx_fmt;
   logic [7:0] rx_fmt;
   logic [7:0] card_mode_read;
   logic [7:0] status_read;

   // Request seen on a fresh strobe, answered one cycle later
   assign bus_req = cyc_i && stb_i && !s.ack;
   assign wr_en   = bus_req && we_i && sel_i[0];

   // Prescaler limit 4^n - 1 from the exponent
   always_comb begin
      unique case (s.smode.prescale_select)
         2'b00: pre_limit = 6'h00;
         2'b01: pre_limit = 6'h03;
         2'b10: pre_limit = 6'h0F;
         2'b11: pre_limit = 6'h3F;
      endcase
   end

   // Smart card base-clock count per bit
   always_comb begin
      unique case (s.smode.base_clock_count)
         2'b00: card_s = SBC_CARD_S0;
         2'b01: card_s = SBC_CARD_S1;
         2'b10: card_s = SBC_CARD_S2;
         2'b11: card_s = SBC_CARD_S3;
      endcase
   end

   // Base ticks per bit; the 2^(2n+-1) factor is split into 4^n and a constant
   always_comb begin
      if (s.card_mode_select) begin
         bits_base = {card_s[8:0], 1'b0};
      end else if (s.smode.sync_mode) begin
         bits_base = SBC_SYNC_BASE;
      end else begin
         bits_base = SBC_ASYNC_BASE;
      end
   end

   assign pre_tick = (s.pre_cnt == pre_limit);

   // Data formatting on both paths, parity never passes through here
   assign tx_fmt = sbc_format(tx_data_i, s.card_data_invert, s.card_bit_order,
                              s.smode.char_seven);
   assign rx_fmt = sbc_format(rx_data_i, s.card_data_invert, s.card_bit_order,
                              s.smode.char_seven);

   // Read views
   assign card_mode_read = SBC_CM_FIXED_ONES
                         | ({7'h00, s.card_bit_order} << SBC_CM_ORDER_BIT)
                         | ({7'h00, s.card_data_invert} << SBC_CM_INV_BIT)
                         | ({7'h00, s.card_mode_select} << SBC_CM_MODE_BIT);
   assign status_read = {4'h0, s.base_tick, s.rx_valid, s.tail_valid, s.head_valid};

   // Stream handshakes
   assign tx_take = tx_valid_i && s.tx_ready;
   assign tx_pop  = s.head_valid && tx_ready_i;
   assign rx_take = rx_valid_i && s.rx_ready;
   assign rx_pop  = s.rx_valid && rx_ready_i;

   // ==========================================================
   // Next state
   always_comb begin
      next_s = s;

      // Register bus answer and writes
      next_s.ack = bus_req;
      next_s.rdata = 32'h0000_0000;
      if (bus_req && !we_i) begin
         unique case (adr_i)
            SBC_OFS_CARD_MODE:   next_s.rdata = {24'h00_0000, card_mode_read};
            SBC_OFS_DIVISOR:     next_s.rdata = {24'h00_0000, s.divisor};
            SBC_OFS_SERIAL_MODE: next_s.rdata = {25'h000_0000, s.smode};
            SBC_OFS_STATUS:      next_s.rdata = {24'h00_0000, status_read};
            default:             next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (wr_en) begin
         unique case (adr_i)
            SBC_OFS_CARD_MODE: begin
               next_s.card_bit_order   = dat_i[SBC_CM_ORDER_BIT];
               next_s.card_data_invert = dat_i[SBC_CM_INV_BIT];
               next_s.card_mode_select = dat_i[SBC_CM_MODE_BIT];
            end
            SBC_OFS_DIVISOR: begin
               next_s.divisor = dat_i[7:0];
            end
            SBC_OFS_SERIAL_MODE: begin
               next_s.smode = dat_i[6:0];
            end
            default: begin
            end
         endcase
      end

      // Prescaler, reloadable divider and per-bit counter of this channel
      next_s.base_tick = 1'b0;
      next_s.bit_tick  = 1'b0;
      if (pre_tick) begin
         next_s.pre_cnt = 6'h00;
         if (s.div_cnt == 8'h00) begin
            next_s.div_cnt   = s.divisor;
            next_s.base_tick = 1'b1;
            if (s.bit_cnt >= bits_base - 10'h001) begin
               next_s.bit_cnt  = 10'h000;
               next_s.bit_tick = 1'b1;
            end else begin
               next_s.bit_cnt = s.bit_cnt + 10'h001;
            end
         end else begin
            next_s.div_cnt = s.div_cnt - 8'h01;
         end
      end else if (s.pre_cnt > pre_limit) begin
         next_s.pre_cnt = 6'h00;
      end else begin
         next_s.pre_cnt = s.pre_cnt + 6'h01;
      end

      // Two-entry transmit buffer: head drives the output, tail absorbs a stall
      if (tx_pop) begin
         next_s.head_valid = s.tail_valid;
         next_s.head_data  = s.tail_data;
         next_s.tail_valid = 1'b0;
      end
      if (tx_take) begin
         if (!next_s.head_valid) begin
            next_s.head_valid = 1'b1;
            next_s.head_data  = tx_fmt;
         end else begin
            next_s.tail_valid = 1'b1;
            next_s.tail_data  = tx_fmt;
         end
      end
      next_s.tx_ready = !next_s.tail_valid;

      // Receive holding register
      if (rx_pop) begin
         next_s.rx_valid = 1'b0;
      end
      if (rx_take) begin
         next_s.rx_valid = 1'b1;
         next_s.rx_data  = rx_fmt;
      end
      next_s.rx_ready = !next_s.rx_valid;
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s                  <= '0;
         s.divisor          <= SBC_DIVISOR_RESET;
         s.div_cnt          <= SBC_DIVISOR_RESET;
         s.smode            <= SBC_SM_RESET;
         s.card_bit_order   <= 1'b0;
         s.card_data_invert <= 1'b0;
         s.tx_ready         <= 1'b1;
         s.rx_ready         <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs, all from the state register
   assign dat_o        = s.rdata;
   assign ack_o        = s.ack;
   assign tx_ready_o   = s.tx_ready;
   assign tx_valid_o   = s.head_valid;
   assign tx_data_o    = s.head_data;
   assign rx_ready_o   = s.rx_ready;
   assign rx_valid_o   = s.rx_valid;
   assign rx_data_o    = s.rx_data;
   assign base_tick_o  = s.base_tick;
   assign bit_tick_o   = s.bit_tick;
   assign card_mode_o  = s.card_mode_select;
   assign sync_mode_o  = s.smode.sync_mode;
   assign char_seven_o = s.smode.char_seven;
   assign parity_odd_o = s.smode.parity_odd;

endmodule : sbc_top

// >>> tb/sbc_top_asserts.sv
// Checker for bus answers, stream holding and bit tick spacing
`timescale 1ns/1ps
module sbc_top_asserts
   import sbc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        tx_ready_i,
   input wire logic        rx_valid_o,
   input wire logic [7:0]  rx_data_o,
   input wire logic        rx_ready_i,
   input wire logic        rx_ready_o,
   input wire logic        bit_tick_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // Bus steps
   sequence s_take;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_card_read;
      ack_o && !we_i && adr_i == SBC_OFS_CARD_MODE;
   endsequence
   // Bus answers
   bus_answer_a: assert property (s_take |=> ack_o)
      else $error("bus request not answered");
   ack_pulse_a: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   idle_data_a: assert property (!ack_o |-> dat_o == 32'h00000000)
      else $error("read data outside ack");
   fixed_ones_a: assert property (s_card_read |-> dat_o[7:4] == 4'hF && dat_o[1])
      else $error("reserved card bits not one");
   // Streams hold under stall
   tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx word lost in stall");
   rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
      else $error("rx word lost in stall");
   rx_block_a: assert property (rx_valid_o |-> !rx_ready_o)
      else $error("rx accepts while full");
   // Shortest bit is four base ticks
   bit_gap_a: assert property (bit_tick_o |=> !bit_tick_o [*3])
      else $error("bit ticks too close");
endmodule : sbc_top_asserts

bind sbc_top sbc_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
   .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
   .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
   .rx_ready_o(rx_ready_o), .bit_tick_o(bit_tick_o));

// >>> tb/sbc_peer.sv
// Far side model: transmit shifter taking formatted characters, can stall
`timescale 1ns/1ps
module sbc_peer (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       stall_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o
);
   logic [7:0] got[$];
   // Ready follows the stall request
   assign tx_ready_o = !stall_i;
   // Record every character taken, in order
   always @(posedge clk_i) begin
      if (!rst_i && tx_valid_i && tx_ready_o) begin
         got.push_back(tx_data_i);
      end
   end
endmodule : sbc_peer

// >>> tb/testbench.sv
// Testbench for the bit-rate generator and card format block
`timescale 1ns/1ps
module testbench
   import sbc_pkg::*;
;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, stall, tx_valid_i, tx_ready_o;
   logic        tx_valid_o, tx_ready_i, rx_valid_i, rx_ready_o, rx_valid_o, rx_ready_i;
   logic        base_tick_o, bit_tick_o, card_mode_o, sync_mode_o, char_seven_o, parity_odd_o;
   logic [7:0]  adr_i, tx_data_i, tx_data_o, rx_data_i, rx_data_o;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, q;
   int          fails, tests_run, k;

   sbc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_ready_o(tx_ready_o),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
      .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
      .base_tick_o(base_tick_o), .bit_tick_o(bit_tick_o), .card_mode_o(card_mode_o),
      .sync_mode_o(sync_mode_o), .char_seven_o(char_seven_o), .parity_odd_o(parity_odd_o));
   sbc_peer peer (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .tx_valid_i(tx_valid_o),
      .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

   // ==========
   // Clock
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ==========
   // Shared tasks
   task test_done;
      $display("Checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Wait for a condition sampled at falling edges, bounded
   task tick_wait(input int lim);
      @(negedge clk_i);
      k++;
      if (k >= lim) begin
         chk(32'h0, 32'h1);
         test_done;
      end
   endtask : tick_wait
   // One classic Wishbone cycle; read data lands in q
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= {2'b11, w};
      adr_i <= a;
      sel_i <= s;
      dat_i <= {24'h000000, d};
      k = 0;
      do tick_wait(50); while (ack_o !== 1'b1);
      q = dat_o;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= 3'b000;
   endtask : wb
   task tx_push(input logic [7:0] d);
      @(posedge clk_i);
      tx_valid_i <= 1'b1;
      tx_data_i <= d;
      k = 0;
      do tick_wait(50); while (tx_ready_o !== 1'b1);
      @(posedge clk_i);
      tx_valid_i <= 1'b0;
      tx_data_i <= ~d;
   endtask : tx_push
   task rx_push(input logic [7:0] d);
      @(posedge clk_i);
      rx_valid_i <= 1'b1;
      rx_data_i <= d;
      k = 0;
      do tick_wait(50); while (rx_ready_o !== 1'b1);
      @(posedge clk_i);
      rx_valid_i <= 1'b0;
      rx_data_i <= ~d;
   endtask : rx_push

   // ==========
   // Scenarios
   task t_regs;
      wb(0, SBC_OFS_CARD_MODE, 8'h00, 4'hF);
      chk(q, 32'h000000F2);
      wb(0, SBC_OFS_DIVISOR, 8'h00, 4'hF);
      chk(q, 32'h000000FF);
      wb(1, SBC_OFS_CARD_MODE, 8'hFF, 4'hF);
      wb(0, SBC_OFS_CARD_MODE, 8'h00, 4'hF);
      chk(q, 32'h000000FF);
      wb(1, SBC_OFS_CARD_MODE, 8'h00, 4'hF);
      wb(0, SBC_OFS_CARD_MODE, 8'h00, 4'hF);
      chk(q, 32'h000000F2);
      wb(1, SBC_OFS_DIVISOR, 8'h00, 4'hE);
      wb(0, SBC_OFS_DIVISOR, 8'h00, 4'hF);
      chk(q, 32'h000000FF);
      wb(1, SBC_OFS_DIVISOR, 8'h00, 4'h1);
      wb(0, SBC_OFS_DIVISOR, 8'h00, 4'hF);
      chk(q, 32'h00000000);
      wb(0, 8'h10, 8'h00, 4'hF);
      chk(q, 32'h00000000);
   endtask : t_regs
   task t_mode;
      wb(1, SBC_OFS_CARD_MODE, 8'h01, 4'hF);
      repeat (2) @(negedge clk_i);
      chk(32'(card_mode_o), 32'h00000001);
      wb(1, SBC_OFS_CARD_MODE, 8'h04, 4'hF);
      wb(1, SBC_OFS_SERIAL_MODE, 8'h70, 4'hF);
      repeat (2) @(negedge clk_i);
      chk(32'(card_mode_o), 32'h00000000);
      chk(32'(parity_odd_o), 32'h00000001);
      chk(32'(sync_mode_o), 32'h00000001);
      chk(32'(char_seven_o), 32'h00000001);
   endtask : t_mode
   task t_fmt;
      logic [7:0] cm [4];
      logic [7:0] sm [4];
      logic [7:0] ex [4];
      cm = '{8'h00, 8'h04, 8'h08, 8'h0C};
      sm = '{8'h00, 8'h00, 8'h00, 8'h10};
      ex = '{8'h3A, 8'hC5, 8'h5C, 8'h45};
      for (int i = 0; i < 4; i++) begin
         wb(1, SBC_OFS_SERIAL_MODE, sm[i], 4'hF);
         wb(1, SBC_OFS_CARD_MODE, cm[i], 4'hF);
         tx_push(8'h3A);
         k = 0;
         while (peer.got.size() == 0) tick_wait(50);
         chk({24'h000000, peer.got.pop_front()}, {24'h000000, ex[i]});
         rx_push(8'h3A);
         k = 0;
         while (rx_valid_o !== 1'b1) tick_wait(50);
         chk({24'h000000, rx_data_o}, {24'h000000, ex[i]});
         repeat (2) @(negedge clk_i);
         chk(32'(rx_ready_o), 32'h00000000);
         @(posedge clk_i);
         rx_ready_i <= 1'b1;
         @(posedge clk_i);
         rx_ready_i <= 1'b0;
      end
   endtask : t_fmt
   task t_buf;
      wb(1, SBC_OFS_CARD_MODE, 8'h00, 4'hF);
      wb(1, SBC_OFS_SERIAL_MODE, 8'h00, 4'hF);
      stall <= 1'b1;
      tx_push(8'h11);
      tx_push(8'h22);
      repeat (2) @(negedge clk_i);
      chk(32'(tx_ready_o), 32'h00000000);
      @(posedge clk_i);
      stall <= 1'b0;
      k = 0;
      while (peer.got.size() < 2) tick_wait(50);
      chk({24'h000000, peer.got.pop_front()}, 32'h00000011);
      chk({24'h000000, peer.got.pop_front()}, 32'h00000022);
   endtask : t_buf
   // Configure, let the old setting drain, then time one bit
   task rate(input logic [7:0] sm, input logic [7:0] n, input logic [7:0] cm, input int exp);
      int p;
      wb(1, SBC_OFS_SERIAL_MODE, sm, 4'hF);
      wb(1, SBC_OFS_DIVISOR, n, 4'hF);
      wb(1, SBC_OFS_CARD_MODE, cm, 4'hF);
      k = 0;
      do tick_wait(20000); while (bit_tick_o !== 1'b1);
      repeat (3) begin
         k = 0;
         do tick_wait(20000); while (bit_tick_o !== 1'b1);
         p = k;
      end
      chk(32'(p), 32'(exp));
   endtask : rate
   task t_rate;
      int s [4];
      s = '{32, 64, 372, 256};
      for (int n = 0; n < 4; n++) rate(8'(n), 8'h00, 8'h00, 32 * (4 ** n));
      for (int b = 0; b < 4; b++) rate(8'(b << 2), 8'h00, 8'h01, 2 * s[b]);
      rate(8'h40, 8'hFF, 8'h00, 4 * 256);
      rate(8'h41, 8'h02, 8'h00, 4 * 4 * 3);
      // Base tick spacing with n = 1, N = 2
      k = 0;
      do tick_wait(100); while (base_tick_o !== 1'b1);
      k = 0;
      do tick_wait(100); while (base_tick_o !== 1'b1);
      chk(32'(k), 32'd12);
   endtask : t_rate

   // Reset, then every scenario in turn
   initial begin
      {rst_i, cyc_i, stb_i, we_i, stall, tx_valid_i, rx_valid_i, rx_ready_i} = 8'h80;
      {adr_i, sel_i, dat_i, tx_data_i, rx_data_i} = 60'h0;
      {fails, tests_run, k} = 96'h0;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_mode;
      t_fmt;
      t_buf;
      t_rate;
      test_done;
   end
endmodule : testbench
